// ==== include/jtb_pkg.sv ====
// constants and types shared by the boundary-scan test port
// assumes one test port per device, clocked by the test clock and the system clock
package jtb_pkg;
   // register lengths
   localparam int IR_LEN = 10;           // instruction register cells
   localparam int ID_LEN = 32;           // identification and user code width
   localparam int BSR_LEN_DEF = 96;      // smallest boundary-scan variant
   // identification word field widths, msb first
   localparam int ID_VER_W = 4;          // version field
   localparam int ID_PART_W = 16;        // part number field
   localparam int ID_MFR_W = 11;         // manufacturer field
   localparam logic ID_LSB = 1'h1;       // fixed trailing bit
   // instruction codes
   localparam logic [9:0] INS_EXTEST = 10'h000;   // drive pins from scan cells
   localparam logic [9:0] INS_SAMPLE = 10'h005;   // sample and preload
   localparam logic [9:0] INS_USERCODE = 10'h007; // user code register
   localparam logic [9:0] INS_IDCODE = 10'h059;   // identification register
   localparam logic [9:0] INS_CLAMP = 10'h0fa;    // hold pins, bypass path
   localparam logic [9:0] INS_BYPASS = 10'h3ff;   // one-cell bypass
   localparam logic [9:0] IR_CAPTURE = 10'h001;   // loaded at capture-ir
   // test controller states, one-hot
   typedef enum logic [15:0] {
      ST_RESET = 16'h0001,
      ST_IDLE = 16'h0002,
      ST_SEL_DR = 16'h0004,
      ST_CAP_DR = 16'h0008,
      ST_SH_DR = 16'h0010,
      ST_EX1_DR = 16'h0020,
      ST_PA_DR = 16'h0040,
      ST_EX2_DR = 16'h0080,
      ST_UPD_DR = 16'h0100,
      ST_SEL_IR = 16'h0200,
      ST_CAP_IR = 16'h0400,
      ST_SH_IR = 16'h0800,
      ST_EX1_IR = 16'h1000,
      ST_PA_IR = 16'h2000,
      ST_EX2_IR = 16'h4000,
      ST_UPD_IR = 16'h8000
   } jtb_st_t;
   // test mode carried from the test clock to the system clock
   typedef struct packed {
      logic drive;    // pins follow the update register
      logic enabled;  // test port enabled
   } jtb_mode_t;
endpackage

// ==== design/jtb_tap_fsm.sv ====
// sixteen-state test controller, stepped by tms on rising tck
// assumes rst_n already released in step with tck
`timescale 1ns/100ps
module jtb_tap_fsm (
   input wire logic tck,               // test clock
   input wire logic rst_n,             // async reset, active low
   input wire logic hold,              // keeps the controller in reset
   input wire logic tms,               // mode select
   output jtb_pkg::jtb_st_t state      // current state
);
   jtb_pkg::jtb_st_t next_state;       // state after this edge

   // successor of a state for a given tms
   function automatic jtb_pkg::jtb_st_t step(jtb_pkg::jtb_st_t s, logic m);
      case (s)
         jtb_pkg::ST_RESET: step = m ? jtb_pkg::ST_RESET : jtb_pkg::ST_IDLE;
         jtb_pkg::ST_IDLE: step = m ? jtb_pkg::ST_SEL_DR : jtb_pkg::ST_IDLE;
         jtb_pkg::ST_SEL_DR: step = m ? jtb_pkg::ST_SEL_IR : jtb_pkg::ST_CAP_DR;
         jtb_pkg::ST_CAP_DR: step = m ? jtb_pkg::ST_EX1_DR : jtb_pkg::ST_SH_DR;
         jtb_pkg::ST_SH_DR: step = m ? jtb_pkg::ST_EX1_DR : jtb_pkg::ST_SH_DR;
         jtb_pkg::ST_EX1_DR: step = m ? jtb_pkg::ST_UPD_DR : jtb_pkg::ST_PA_DR;
         jtb_pkg::ST_PA_DR: step = m ? jtb_pkg::ST_EX2_DR : jtb_pkg::ST_PA_DR;
         jtb_pkg::ST_EX2_DR: step = m ? jtb_pkg::ST_UPD_DR : jtb_pkg::ST_SH_DR;
         jtb_pkg::ST_UPD_DR: step = m ? jtb_pkg::ST_SEL_DR : jtb_pkg::ST_IDLE;
         jtb_pkg::ST_SEL_IR: step = m ? jtb_pkg::ST_RESET : jtb_pkg::ST_CAP_IR;
         jtb_pkg::ST_CAP_IR: step = m ? jtb_pkg::ST_EX1_IR : jtb_pkg::ST_SH_IR;
         jtb_pkg::ST_SH_IR: step = m ? jtb_pkg::ST_EX1_IR : jtb_pkg::ST_SH_IR;
         jtb_pkg::ST_EX1_IR: step = m ? jtb_pkg::ST_UPD_IR : jtb_pkg::ST_PA_IR;
         jtb_pkg::ST_PA_IR: step = m ? jtb_pkg::ST_EX2_IR : jtb_pkg::ST_PA_IR;
         jtb_pkg::ST_EX2_IR: step = m ? jtb_pkg::ST_UPD_IR : jtb_pkg::ST_SH_IR;
         jtb_pkg::ST_UPD_IR: step = m ? jtb_pkg::ST_SEL_DR : jtb_pkg::ST_IDLE;
         default: step = jtb_pkg::ST_RESET;
      endcase
   endfunction

   // hold forces reset, otherwise follow tms
   assign next_state = hold ? jtb_pkg::ST_RESET : step(state, tms);

   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         state <= jtb_pkg::ST_RESET;
      end else begin
         state <= next_state;
      end
   end

   a_tms_five_reset: assert property (@(posedge tck) disable iff (!rst_n)
      tms [*5] |=> (state == jtb_pkg::ST_RESET))
      else $error("five tms highs did not reach reset");
endmodule

// ==== design/jtb_tap.sv ====
// boundary-scan test port: controller, instruction and data registers, pin control
// assumes tck, tms, tdi come from a test controller; pins and core on clk_sys
`timescale 1ns/100ps
module jtb_tap #(
   parameter int BSR_LEN = jtb_pkg::BSR_LEN_DEF,       // 96, 192, 288, 480 or 624
   parameter logic [31:0] USERCODE = 32'hffff_ffff,    // user code word
   parameter logic [3:0] ID_VERSION = 4'h1,            // arbitrary value
   parameter logic [15:0] ID_PART = 16'h1234,          // arbitrary value
   parameter logic [10:0] ID_MFR = 11'h0ab             // arbitrary value
) (
   input wire logic clk_sys,                 // system clock
   input wire logic nrst,                    // async reset, active low
   input wire logic test_en,                 // test port enabled in configuration
   input wire logic tck,                     // test clock
   input wire logic tms,                     // test mode select
   input wire logic tdi,                     // test data in
   output logic tdo,                         // test data out
   output logic tdo_oe_n,                    // tdo driven when low
   input wire logic [BSR_LEN-1:0] pin_in,    // levels seen at the pins
   input wire logic [BSR_LEN-1:0] core_out,  // levels the core wants on the pins
   output logic [BSR_LEN-1:0] pin_out,       // levels sent to the pins
   output logic pins_user,                   // test pins free as user i/o
   output logic test_drive                   // pins follow the scan cells
);
   localparam logic [31:0] ID_WORD = {ID_VERSION, ID_PART, ID_MFR, jtb_pkg::ID_LSB};
   localparam int IRL = jtb_pkg::IR_LEN;     // instruction length
   localparam int IDL = jtb_pkg::ID_LEN;     // id and user code length

   // ---------------- test clock domain ----------------
   logic [1:0] trst_q;                  // reset release synchroniser on tck
   logic tck_rst_n;                     // tck domain reset
   logic en_s1;                         // enable sync, first stage
   logic en_s2;                         // enable sync, second stage
   logic [BSR_LEN-1:0] pin_s1;          // pin sync, first stage
   logic [BSR_LEN-1:0] pin_s2;          // pin sync, second stage
   jtb_pkg::jtb_st_t state;             // controller state
   logic [IRL-1:0] ir_sh;               // instruction shift stage
   logic [IRL-1:0] ir;                  // active instruction
   logic [BSR_LEN-1:0] bsr_sh;          // boundary shift stage
   logic [BSR_LEN-1:0] bsr_upd;         // boundary update stage
   logic [IDL-1:0] id_sh;               // id or user code shift stage
   logic byp;                           // bypass cell
   logic [BSR_LEN-1:0] xfer;            // word held for the system clock
   logic req;                           // transfer toggle toward clk_sys
   logic dirty;                         // update waiting for transfer
   logic ack_s1;                        // ack sync, first stage
   logic ack_s2;                        // ack sync, second stage
   logic ack;                           // acknowledge toggle, driven on clk_sys

   // state decode
   wire cap_dr = (state == jtb_pkg::ST_CAP_DR);
   wire sh_dr = (state == jtb_pkg::ST_SH_DR);
   wire upd_dr = (state == jtb_pkg::ST_UPD_DR);
   wire cap_ir = (state == jtb_pkg::ST_CAP_IR);
   wire sh_ir = (state == jtb_pkg::ST_SH_IR);
   wire upd_ir = (state == jtb_pkg::ST_UPD_IR);
   wire in_reset = (state == jtb_pkg::ST_RESET);
   wire shifting = sh_dr | sh_ir;

   // instructions that hand the pins to the scan cells
   function automatic logic is_drive(logic [9:0] code);
      is_drive = (code == jtb_pkg::INS_EXTEST) | (code == jtb_pkg::INS_CLAMP);
   endfunction

   // data register selection; anything unknown falls to bypass
   wire sel_bsr = (ir == jtb_pkg::INS_EXTEST) | (ir == jtb_pkg::INS_SAMPLE);
   wire sel_id = (ir == jtb_pkg::INS_IDCODE);
   wire sel_uc = (ir == jtb_pkg::INS_USERCODE);
   wire sel_byp = !(sel_bsr | sel_id | sel_uc);

   // reset release in step with tck
   always_ff @(posedge tck or negedge nrst) begin
      if (!nrst) begin
         trst_q <= 2'h0;
      end else begin
         trst_q <= {trst_q[0], 1'h1};
      end
   end
   assign tck_rst_n = trst_q[1];

   // enable and pin levels cross into tck
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         en_s1 <= 1'h0;
         en_s2 <= 1'h0;
         pin_s1 <= '0;
         pin_s2 <= '0;
      end else begin
         en_s1 <= test_en;
         en_s2 <= en_s1;
         pin_s1 <= pin_in;
         pin_s2 <= pin_s1;
      end
   end

   // controller; held in reset while the port is disabled
   jtb_tap_fsm u_fsm (
      .tck(tck),
      .rst_n(tck_rst_n),
      .hold(!en_s2),
      .tms(tms),
      .state(state)
   );

   // ten-cell instruction path, capture pattern then shift
   wire [IRL-1:0] next_ir_sh = cap_ir ? jtb_pkg::IR_CAPTURE
      : (sh_ir ? {tdi, ir_sh[IRL-1:1]} : ir_sh);
   wire [IRL-1:0] next_ir = in_reset ? jtb_pkg::INS_IDCODE : (upd_ir ? ir_sh : ir);

   // instruction registers
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         ir_sh <= jtb_pkg::IR_CAPTURE;
         ir <= jtb_pkg::INS_IDCODE;
      end else begin
         ir_sh <= next_ir_sh;
         ir <= next_ir;
      end
   end

   // capture pins, shift pattern through the chain
   wire [BSR_LEN-1:0] next_bsr_sh = (cap_dr && sel_bsr) ? pin_s2
      : ((sh_dr && sel_bsr) ? {tdi, bsr_sh[BSR_LEN-1:1]} : bsr_sh);
   // preload or extest pattern lands in the update stage
   wire [BSR_LEN-1:0] next_bsr_upd = (upd_dr && sel_bsr) ? bsr_sh : bsr_upd;
   wire [IDL-1:0] cap_word = sel_uc ? USERCODE : ID_WORD;
   wire [IDL-1:0] next_id_sh = (cap_dr && (sel_id || sel_uc)) ? cap_word
      : ((sh_dr && (sel_id || sel_uc)) ? {tdi, id_sh[IDL-1:1]} : id_sh);
   wire next_byp = (cap_dr && sel_byp) ? 1'h0 : ((sh_dr && sel_byp) ? tdi : byp);

   // data registers
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         bsr_sh <= '0;
         bsr_upd <= '0;
         id_sh <= '0;
         byp <= 1'h0;
      end else begin
         bsr_sh <= next_bsr_sh;
         bsr_upd <= next_bsr_upd;
         id_sh <= next_id_sh;
         byp <= next_byp;
      end
   end

   // bit presented on tdo
   wire dr_bit = sel_bsr ? bsr_sh[0] : ((sel_id || sel_uc) ? id_sh[0] : byp);
   wire tdo_bit = sh_ir ? ir_sh[0] : dr_bit;

   // tdo moves on falling tck, driven only while shifting
   always_ff @(negedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         tdo <= 1'h0;
         tdo_oe_n <= 1'h1;
      end else begin
         tdo <= shifting ? tdo_bit : tdo;
         tdo_oe_n <= !shifting;
      end
   end

   // update word handed over only when the previous one was taken
   wire xfer_idle = (req == ack_s2);
   wire launch = xfer_idle && (dirty || (upd_dr && sel_bsr));
   wire [BSR_LEN-1:0] next_xfer = launch ? next_bsr_upd : xfer;
   // a new update while busy stays pending; when idle, dirty clears as the update launches at once
   wire next_dirty = (upd_dr && sel_bsr && !xfer_idle) || (dirty && !xfer_idle);

   // transfer toward the system clock
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         xfer <= '0;
         req <= 1'h0;
         dirty <= 1'h0;
         ack_s1 <= 1'h0;
         ack_s2 <= 1'h0;
      end else begin
         xfer <= next_xfer;
         req <= launch ? !req : req;
         dirty <= next_dirty;
         ack_s1 <= ack;
         ack_s2 <= ack_s1;
      end
   end

   // mode presented to the system clock, from a flop so the synchroniser sees no glitch
   jtb_pkg::jtb_mode_t mode_tck;        // mode launched toward clk_sys
   wire next_drive = en_s2 && is_drive(ir);
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         mode_tck <= '0;
      end else begin
         mode_tck.drive <= next_drive;
         mode_tck.enabled <= en_s2;
      end
   end

   // ---------------- system clock domain ----------------
   jtb_pkg::jtb_mode_t mode_s1;          // mode sync, first stage
   jtb_pkg::jtb_mode_t mode_s2;          // mode sync, second stage
   logic req_s1;                         // request sync, first stage
   logic req_s2;                         // request sync, second stage
   logic req_s3;                         // request edge detect
   logic [BSR_LEN-1:0] sys_upd;          // update word in clk_sys
   logic en_q;                           // registered enable

   wire take = (req_s2 != req_s3);

   // synchronisers into clk_sys
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mode_s1 <= '0;
         mode_s2 <= '0;
         req_s1 <= 1'h0;
         req_s2 <= 1'h0;
         req_s3 <= 1'h0;
      end else begin
         mode_s1 <= mode_tck;
         mode_s2 <= mode_s1;
         req_s1 <= req;
         req_s2 <= req_s1;
         req_s3 <= req_s2;
      end
   end

   // accept the update word; xfer is stable until ack returns
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sys_upd <= '0;
         ack <= 1'h0;
      end else begin
         sys_upd <= take ? xfer : sys_upd;
         ack <= req_s2;
      end
   end

   // pins follow the scan cells under extest or clamp
   wire [BSR_LEN-1:0] next_pin_out = mode_s2.drive ? sys_upd : core_out;

   // pin drive and status
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pin_out <= '0;
         test_drive <= 1'h0;
         en_q <= 1'h0;
         pins_user <= 1'h1;
      end else begin
         pin_out <= next_pin_out;
         test_drive <= mode_s2.drive;
         en_q <= test_en;
         // pins released when the port is off
         pins_user <= !test_en;
      end
   end

   // ---------------- checks ----------------
   a_ir_capture_pattern: assert property (@(posedge tck) disable iff (!tck_rst_n)
      cap_ir |=> (ir_sh == jtb_pkg::IR_CAPTURE))
      else $error("instruction capture pattern wrong");

   a_ir_shift_in: assert property (@(posedge tck) disable iff (!tck_rst_n)
      sh_ir |=> (ir_sh[IRL-1] == $past(tdi)) && (ir_sh[IRL-2] == $past(ir_sh[IRL-1])))
      else $error("instruction shift wrong");

   a_bypass_one_cell: assert property (@(posedge tck) disable iff (!tck_rst_n)
      (sh_dr && sel_byp) |=> (byp == $past(tdi)))
      else $error("bypass cell did not take tdi");

   a_id_word_capture: assert property (@(posedge tck) disable iff (!tck_rst_n)
      (cap_dr && sel_id) |=> (id_sh == ID_WORD) && id_sh[0])
      else $error("identification word wrong");

   a_user_code_capture: assert property (@(posedge tck) disable iff (!tck_rst_n)
      (cap_dr && sel_uc) |=> (id_sh == USERCODE))
      else $error("user code wrong");

   a_bsr_pin_capture: assert property (@(posedge tck) disable iff (!tck_rst_n)
      (cap_dr && sel_bsr) |=> (bsr_sh == $past(pin_s2)))
      else $error("boundary capture wrong");

   a_bsr_preload_update: assert property (@(posedge tck) disable iff (!tck_rst_n)
      (upd_dr && sel_bsr) |=> (bsr_upd == $past(bsr_sh)))
      else $error("boundary update wrong");

   a_tdo_shift_only: assert property (@(negedge tck) disable iff (!tck_rst_n)
      shifting |=> !tdo_oe_n)
      else $error("tdo not driven in shift");

   a_tdo_idle_released: assert property (@(negedge tck) disable iff (!tck_rst_n)
      !shifting |=> tdo_oe_n)
      else $error("tdo driven outside shift");

   a_pins_follow_cells: assert property (@(posedge clk_sys) disable iff (!nrst)
      mode_s2.drive |=> (pin_out == $past(sys_upd)) && test_drive)
      else $error("pins not driven from scan cells");

   a_pins_user_io: assert property (@(posedge clk_sys) disable iff (!nrst)
      (!en_q && !test_en) |=> pins_user && !test_drive [*1])
      else $error("pins not released when disabled");
endmodule

// ==== sim/jtb_ctl_model.sv ====
// test controller model that drives the scan link of the boundary-scan port
// assumes a weak pull-up on tdo and a tck that stands still between frames
`timescale 1ns/100ps
module jtb_ctl_model (
   output logic tck,         // test clock, low while idle
   output logic tms,         // mode select
   output logic tdi,         // data toward the port
   input wire logic tdo,     // data from the port
   input wire logic tdo_oe_n // tdo driven when low
);
   logic oe_seen; // enable sampled at the last rising edge

   // idle levels before the first frame
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h0;
      oe_seen = 1'h1;
   end

   task automatic tick(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #24;
      tck = 1'h1;
      oe_seen = tdo_oe_n;
      // a released tdo reads high through the pull-up
      q = tdo_oe_n ? 1'h1 : tdo;
      #24;
      tck = 1'h0;
   endtask

   // free ticks in idle; tdi toggles so stale data is never mistaken for data
   task automatic idle(input int n);
      logic q;
      repeat (n) tick(1'h0, ~tdi, q);
   endtask

   // six ones reach test-logic-reset from any state, then idle
   task automatic reset_tap();
      logic q;
      repeat (6) tick(1'h1, ~tdi, q);
      tick(1'h0, ~tdi, q);
   endtask

   // exact scan length, lsb first, from idle back to idle
   task automatic scan(input logic ir, input int n, input logic [95:0] din,
                       output logic [95:0] dout, output logic oe_hi);
      logic q;
      dout = '0;
      oe_hi = 1'h0;
      tick(1'h1, ~tdi, q);
      if (ir) tick(1'h1, ~tdi, q);
      tick(1'h0, ~tdi, q);
      tick(1'h0, ~tdi, q);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], q);
         dout[i] = q;
         // any released bit inside the shift is noted
         if (oe_seen !== 1'h0) oe_hi = 1'h1;
      end
      tick(1'h1, ~tdi, q);
      tick(1'h0, ~tdi, q);
   endtask
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench for the boundary-scan port with the controller model
// assumes the smallest boundary variant and a 48 ns test clock in frames only
`timescale 1ns/100ps
module tb_top;
   localparam logic [31:0] UCODE = 32'h5a5a_c3c3;                    // user code
   localparam logic [31:0] ID_EXP = {4'h1, 16'h1234, 11'h0ab, 1'h1}; // expected id
   localparam logic [95:0] PAT_A = {3{32'h1357_9bdf}}; // core levels
   localparam logic [95:0] PAT_B = {3{32'hc0de_0f0f}}; // pins in sample
   localparam logic [95:0] PAT_C = {3{32'h8421_7e5a}}; // preload
   localparam logic [95:0] PAT_D = {3{32'h33cc_a55a}}; // pins in extest
   localparam logic [95:0] PAT_E = {3{32'hf00d_1234}}; // extest pattern
   logic clk_sys, nrst, test_en; // system side inputs
   logic tck, tms, tdi, tdo, tdo_oe_n; // scan link
   logic pins_user, test_drive; // pin control outputs
   logic [95:0] pin_in, core_out, pin_out; // boundary levels
   logic [95:0] pin_src; // levels forced onto the pins from the board
   logic loop_on; // pins wired back to themselves on the board
   assign pin_in = loop_on ? pin_out : pin_src; // board loop for the interconnect check
   logic [95:0] dout; // last scan result
   logic oe_hi; // tdo released inside last scan
   int bad_count, n_tests; // mismatches and comparisons

   jtb_tap #(.BSR_LEN(96), .USERCODE(UCODE)) dut (
      .clk_sys(clk_sys), .nrst(nrst), .test_en(test_en), .tck(tck), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pin_in(pin_in),
      .core_out(core_out), .pin_out(pin_out), .pins_user(pins_user),
      .test_drive(test_drive)
   );

   jtb_ctl_model ctl (
      .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n)
   );

   // system clock, 100 MHz
   initial clk_sys = 1'h0;
   always #5 clk_sys = ~clk_sys;

   // compare and count
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // single place where the run ends
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // load an opcode and check the captured instruction pattern
   task automatic ir_load(input logic [9:0] op);
      ctl.scan(1'h1, 10, {86'h0, op}, dout, oe_hi);
      chk(dout, {86'h0, jtb_pkg::IR_CAPTURE}); // ten-cell capture
      ctl.idle(4);
   endtask

   // wait, bounded, for the pins to settle on a level and drive mode
   task automatic wait_pins(input logic [95:0] exp, input logic drv);
      int k;
      k = 0;
      while (k < 200 && !(pin_out === exp && test_drive === drv)) begin
         @(negedge clk_sys);
         k++;
      end
      chk(pin_out, exp);
      chk({95'h0, test_drive}, {95'h0, drv});
      if (k == 200) tally_and_finish();
   endtask

   // one-bit path: data returns one tck late behind a captured zero
   task automatic bypass_scan();
      ctl.scan(1'h0, 8, {88'h0, 8'hb5}, dout, oe_hi);
      chk(dout, {88'h0, 8'h6a}); // single cell delay
   endtask

   task automatic t_idcode();
      ctl.scan(1'h0, 32, 96'h0, dout, oe_hi);
      chk(dout, {64'h0, ID_EXP}); // id word after reset
      chk({95'h0, oe_hi}, 96'h0); // tdo driven in shift
      ir_load(jtb_pkg::INS_IDCODE); // explicit load
      ctl.scan(1'h0, 32, {3{32'hffff_ffff}}, dout, oe_hi);
      chk(dout, {64'h0, ID_EXP}); // field order and trailing one
      $display("test idcode done");
   endtask

   task automatic t_usercode();
      ir_load(jtb_pkg::INS_USERCODE);
      ctl.scan(1'h0, 32, 96'h0, dout, oe_hi);
      chk(dout, {64'h0, UCODE}); // user code out
      $display("test usercode done");
   endtask

   task automatic t_bypass();
      logic [9:0] ops [2];
      ops[0] = jtb_pkg::INS_BYPASS;
      ops[1] = 10'h155;
      // documented opcode and an unknown one behave the same
      foreach (ops[i]) begin
         ir_load(ops[i]);
         bypass_scan(); // bypass path
      end
      $display("test bypass done");
   endtask

   task automatic t_sample();
      @(negedge clk_sys);
      core_out = PAT_A;
      pin_src = PAT_B;
      ir_load(jtb_pkg::INS_SAMPLE);
      ctl.scan(1'h0, 96, PAT_C, dout, oe_hi);
      chk(dout, PAT_B); // full-length pin snapshot
      ctl.idle(4);
      wait_pins(PAT_A, 1'h0); // core keeps the pins
      $display("test sample done");
   endtask

   task automatic t_extest();
      @(negedge clk_sys);
      pin_src = PAT_D;
      ir_load(jtb_pkg::INS_EXTEST);
      wait_pins(PAT_C, 1'h1); // preload driven
      ctl.scan(1'h0, 96, PAT_E, dout, oe_hi);
      chk(dout, PAT_D); // input levels captured
      ctl.idle(4);
      wait_pins(PAT_E, 1'h1); // new pattern driven
      // close the board loop: the driven levels must come back as captured inputs
      @(negedge clk_sys);
      loop_on = 1'h1;
      ctl.idle(4);
      ctl.scan(1'h0, 96, PAT_E, dout, oe_hi);
      chk(dout, PAT_E); // interconnect read back
      @(negedge clk_sys);
      loop_on = 1'h0;
      $display("test extest done");
   endtask

   task automatic t_clamp();
      ir_load(jtb_pkg::INS_CLAMP);
      wait_pins(PAT_E, 1'h1); // pins held from scan cells
      bypass_scan(); // bypass selected
      ir_load(jtb_pkg::INS_BYPASS);
      wait_pins(PAT_A, 1'h0); // normal operation again
      $display("test clamp done");
   endtask

   task automatic t_disable();
      @(negedge clk_sys);
      test_en = 1'h0;
      ctl.idle(4);
      chk({95'h0, pins_user}, {95'h0, 1'h1}); // pins freed
      ctl.scan(1'h0, 32, 96'h0, dout, oe_hi);
      chk(dout, {64'h0, 32'hffff_ffff}); // tdo released
      chk({95'h0, oe_hi}, {95'h0, 1'h1}); // no drive on tdo
      @(negedge clk_sys);
      test_en = 1'h1;
      ctl.idle(4);
      ctl.reset_tap();
      chk({95'h0, pins_user}, 96'h0); // pins back to test use
      ctl.scan(1'h0, 32, 96'h0, dout, oe_hi);
      chk(dout, {64'h0, ID_EXP}); // controller restarts
      $display("test disable done");
   endtask

   // main sequence
   initial begin
      bad_count = 0;
      n_tests = 0;
      nrst = 1'h0;
      test_en = 1'h1;
      pin_src = 96'h0;
      loop_on = 1'h0;
      core_out = 96'h0;
      repeat (2) @(negedge clk_sys);
      chk({94'h0, pins_user, test_drive}, {94'h0, 2'h2}); // levels in reset
      nrst = 1'h1;
      ctl.reset_tap();
      t_idcode();
      t_usercode();
      t_bypass();
      t_sample();
      t_extest();
      t_clamp();
      t_disable();
      tally_and_finish();
   end

   // cuts a hang short
   initial begin
      #200_000;
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'h0, 1'h1);
      tally_and_finish();
   end
endmodule
